// ### src/rsp_cfg.svh
// Constants of the regulator serial port: address, register space, timing.
// Assumes inclusion by bare name from the package and both ends.
`ifndef RSP_CFG_SVH
`define RSP_CFG_SVH
`define RSP_SLAVE_ADDR 7'h5b
`define RSP_REG_LAST 6'h03
`define RSP_REG_COUNT 4
`define RSP_CMD_BITS 6
`define RSP_CLK_HZ 20000000
`define RSP_SCL_NS 10000
`define RSP_SCL_HALF ((`RSP_CLK_HZ / 1000) * `RSP_SCL_NS / 2000000)
`endif

// ### src/rsp_pkg.sv
// Types shared by both ends of the regulator serial port.
// Assumes rsp_cfg.svh on the include path.
`default_nettype none
`include "rsp_cfg.svh"
package rsp_pkg;
    typedef logic [7:0] rsp_byte_t;
    typedef logic [`RSP_CMD_BITS-1:0] rsp_reg_addr_t;

    // ---------------------------------------------------------------
    // Slave states
    // ---------------------------------------------------------------
    typedef enum logic [6:0] {
        RSP_S_IDLE = 7'h01,
        RSP_S_RX = 7'h02,
        RSP_S_ACK = 7'h04,
        RSP_S_TX = 7'h08,
        RSP_S_MACK = 7'h10,
        RSP_S_IGNORE = 7'h20,
        RSP_S_WAIT = 7'h40
    } rsp_sl_state_t;

    // ---------------------------------------------------------------
    // Master states
    // ---------------------------------------------------------------
    typedef enum logic [6:0] {
        RSP_M_IDLE = 7'h01,
        RSP_M_START = 7'h02,
        RSP_M_BIT = 7'h04,
        RSP_M_ACK = 7'h08,
        RSP_M_RSTART = 7'h10,
        RSP_M_STOP = 7'h20,
        RSP_M_DONE = 7'h40
    } rsp_ms_state_t;

    function automatic logic rsp_reg_valid(input rsp_reg_addr_t a);
        return a <= `RSP_REG_LAST;
    endfunction
endpackage
`default_nettype wire

// ### src/rsp_bus_if.sv
// Two-wire bus between regulator port and its master.
// Assumes pull-ups: a line is low while any party enables its driver.
`default_nettype none
interface rsp_bus_if;
    logic scl_m_oe;
    logic sda_m_oe;
    logic sda_s_oe;
    logic scl;
    logic sda;
    // Open drain wired-and; no party drives high
    assign scl = ~scl_m_oe;
    assign sda = ~(sda_m_oe | sda_s_oe);
    modport device (input scl, input sda, output sda_s_oe);
    modport master (input scl, input sda, output scl_m_oe, output sda_m_oe);
endinterface
`default_nettype wire

// ### src/rsp_slave.sv
// Regulator serial slave: address match, command decode, one-byte read/write.
// Assumes the bus interface and a register file on the user side.
`default_nettype none
`include "rsp_cfg.svh"
module rsp_slave (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    rsp_bus_if.device bus,
    output logic wr_en_o,
    output logic [5:0] wr_addr_o,
    output logic [7:0] wr_data_o,
    output logic [5:0] rd_addr_o,
    input wire logic [7:0] rd_data_i,
    output logic busy_o
);
    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        // Two-flop synchronisers on both lines
        logic [1:0] scl_sy;
        logic [1:0] sda_sy;
        logic scl_q;
        logic sda_q;
        rsp_pkg::rsp_sl_state_t st;
        logic [3:0] cnt;
        rsp_pkg::rsp_byte_t sh;
        logic [1:0] phase;
        logic rd;
        logic ack;
        logic sda_oe;
        logic busy;
        logic wr_en;
        logic [5:0] reg_a;
        rsp_pkg::rsp_byte_t wdat;
    } rsp_sl_t;

    rsp_sl_t r;
    rsp_sl_t next_r;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    rsp_pkg::rsp_byte_t rxb;

    // ---------------------------------------------------------------
    // Line sampling
    // ---------------------------------------------------------------
    // Second stage only feeds logic
    assign scl = r.scl_sy[1];
    assign sda = r.sda_sy[1];
    assign scl_rise = scl & ~r.scl_q;
    assign scl_fall = ~scl & r.scl_q;
    assign start_c = scl & r.scl_q & r.sda_q & ~sda;
    assign stop_c = scl & r.scl_q & ~r.sda_q & sda;
    assign rxb = {r.sh[6:0], sda};

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.scl_sy = {r.scl_sy[0], bus.scl};
        next_r.sda_sy = {r.sda_sy[0], bus.sda};
        next_r.scl_q = scl;
        next_r.sda_q = sda;
        next_r.wr_en = 1'b0;
        if (start_c) begin
            // Aborts any byte; no write issued
            next_r.busy = 1'b1;
            next_r.st = rsp_pkg::RSP_S_RX;
            next_r.cnt = 4'h0;
            next_r.phase = 2'h0;
            next_r.sda_oe = 1'b0;
        end else if (stop_c) begin
            next_r.busy = 1'b0;
            next_r.st = rsp_pkg::RSP_S_IDLE;
            next_r.sda_oe = 1'b0;
        end else begin
            unique case (r.st)
                rsp_pkg::RSP_S_IDLE, rsp_pkg::RSP_S_IGNORE: begin
                    // Foreign address: off the line until next start or stop
                    next_r.sda_oe = 1'b0;
                end
                rsp_pkg::RSP_S_RX: begin
                    // Data passes the same delay as the clock, so order holds
                    if (scl_rise) begin
                        next_r.sh = rxb;
                        next_r.cnt = r.cnt + 4'h1;
                        if (r.cnt == 4'h7) begin
                            next_r.st = rsp_pkg::RSP_S_WAIT;
                            unique case (r.phase)
                                2'h0: begin
                                    next_r.ack = (rxb[7:1] == `RSP_SLAVE_ADDR);
                                    next_r.rd = rxb[0];
                                end
                                2'h1: begin
                                    // Bad command NACKed either direction
                                    next_r.ack = rsp_pkg::rsp_reg_valid(rxb[5:0]);
                                    next_r.reg_a = rxb[5:0];
                                end
                                default: begin
                                    next_r.ack = 1'b1;
                                    next_r.wdat = rxb;
                                end
                            endcase
                        end
                    end
                end
                rsp_pkg::RSP_S_WAIT: begin
                    // Drive only after the fall, never with clock high
                    if (scl_fall) begin
                        next_r.st = r.ack ? rsp_pkg::RSP_S_ACK : rsp_pkg::RSP_S_IGNORE;
                        next_r.sda_oe = r.ack;
                    end
                end
                rsp_pkg::RSP_S_ACK: begin
                    if (scl_fall) begin
                        next_r.cnt = 4'h0;
                        next_r.sda_oe = 1'b0;
                        if (r.phase == 2'h0 && r.rd) begin
                            // Read data taken here; later register changes are missed
                            next_r.st = rsp_pkg::RSP_S_TX;
                            next_r.sh = rd_data_i;
                            next_r.sda_oe = ~rd_data_i[7];
                            next_r.cnt = 4'h1;
                        end else if (r.phase == 2'h2) begin
                            next_r.wr_en = 1'b1;
                            next_r.st = rsp_pkg::RSP_S_IGNORE;
                        end else begin
                            next_r.phase = r.phase + 2'h1;
                            next_r.st = rsp_pkg::RSP_S_RX;
                        end
                    end
                end
                rsp_pkg::RSP_S_TX: begin
                    // Each bit moves just after a fall, a whole low phase of setup
                    if (scl_fall) begin
                        if (r.cnt == 4'h8) begin
                            next_r.sda_oe = 1'b0;
                            next_r.st = rsp_pkg::RSP_S_MACK;
                        end else begin
                            next_r.sda_oe = ~r.sh[3'(7 - r.cnt)];
                            next_r.cnt = r.cnt + 4'h1;
                        end
                    end
                end
                rsp_pkg::RSP_S_MACK: begin
                    // Single byte only; line stays released after
                    if (scl_fall) begin
                        next_r.st = rsp_pkg::RSP_S_IGNORE;
                    end
                end
                default: next_r.st = rsp_pkg::RSP_S_IDLE;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            r <= '{scl_sy: 2'h3, sda_sy: 2'h3, scl_q: 1'b1, sda_q: 1'b1, st: rsp_pkg::RSP_S_IDLE,
                   cnt: 4'h0, sh: 8'h00, phase: 2'h0, rd: 1'b0, ack: 1'b0, sda_oe: 1'b0,
                   busy: 1'b0, wr_en: 1'b0, reg_a: 6'h00, wdat: 8'h00};
        end else begin
            r <= next_r;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    // Data line only; clock never driven
    assign bus.sda_s_oe = r.sda_oe;
    assign wr_en_o = r.wr_en;
    assign wr_addr_o = r.reg_a;
    assign wr_data_o = r.wdat;
    assign rd_addr_o = r.reg_a;
    assign busy_o = r.busy;
endmodule
`default_nettype wire

// ### src/rsp_master.sv
// Bus master: single write or single read to the regulator port.
// Assumes bus interface; user holds request until done pulse.
`default_nettype none
`include "rsp_cfg.svh"
module rsp_master #(
    parameter int HALF = `RSP_SCL_HALF
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    rsp_bus_if.master bus,
    input wire logic req_i,
    input wire logic rd_i,
    input wire logic [6:0] dev_i,
    input wire logic [5:0] reg_i,
    input wire logic [7:0] wdata_i,
    output logic busy_o,
    output logic done_o,
    output logic nack_o,
    output logic [7:0] rdata_o
);
    // The divider is sixteen bits wide
    if (HALF < 2 || HALF > 65535) begin : g_half_check
        $error("HALF out of range");
    end

    typedef struct packed {
        logic [1:0] sda_sy;
        rsp_pkg::rsp_ms_state_t st;
        logic [15:0] div;
        logic ph;
        logic [2:0] bit_n;
        logic [1:0] byte_n;
        rsp_pkg::rsp_byte_t sh;
        logic scl_oe;
        logic sda_oe;
        logic rd;
        logic done;
        logic nack;
        rsp_pkg::rsp_byte_t rdata;
    } rsp_ms_t;

    rsp_ms_t r;
    rsp_ms_t next_r;
    logic tick;
    logic sda;
    logic rx_byte;

    assign sda = r.sda_sy[1];
    assign tick = (r.div == 16'(HALF - 1));
    // Fourth byte of a read is data from the slave
    assign rx_byte = r.rd && r.byte_n == 2'h3;

    // ---------------------------------------------------------------
    // Sequencer, one step per tick of HALF cycles, three steps per bit
    // ---------------------------------------------------------------
    always_comb begin
        next_r = r;
        next_r.sda_sy = {r.sda_sy[0], bus.sda};
        next_r.done = 1'b0;
        next_r.div = tick ? 16'h0000 : r.div + 16'h0001;
        if (tick) begin
            unique case (r.st)
                rsp_pkg::RSP_M_IDLE: begin
                    // Start only with the data line high
                    if (req_i && sda) begin
                        next_r.st = rsp_pkg::RSP_M_START;
                        next_r.sda_oe = 1'b1;
                        next_r.rd = rd_i;
                        next_r.byte_n = 2'h0;
                        next_r.nack = 1'b0;
                    end
                end
                rsp_pkg::RSP_M_START: begin
                    next_r.scl_oe = 1'b1;
                    next_r.st = rsp_pkg::RSP_M_BIT;
                    next_r.bit_n = 3'h7;
                    next_r.ph = 1'b0;
                    next_r.sh = (r.byte_n == 2'h2 && r.rd) ? {dev_i, 1'b1} : {dev_i, 1'b0};
                end
                rsp_pkg::RSP_M_BIT: begin
                    if (!r.ph) begin
                        // Change data only while clock low
                        next_r.sda_oe = rx_byte ? 1'b0 : ~r.sh[7];
                        next_r.scl_oe = 1'b1;
                        next_r.ph = 1'b1;
                    end else if (r.scl_oe) begin
                        next_r.scl_oe = 1'b0;
                    end else begin
                        next_r.scl_oe = 1'b1;
                        next_r.sh = {r.sh[6:0], sda};
                        next_r.ph = 1'b0;
                        next_r.bit_n = r.bit_n - 3'h1;
                        if (r.bit_n == 3'h0) begin
                            next_r.st = rsp_pkg::RSP_M_ACK;
                        end
                    end
                end
                rsp_pkg::RSP_M_ACK: begin
                    if (!r.ph) begin
                        // Master NACKs the read byte
                        next_r.sda_oe = 1'b0;
                        next_r.ph = 1'b1;
                        if (rx_byte) begin
                            next_r.rdata = r.sh;
                        end
                    end else if (r.scl_oe) begin
                        next_r.scl_oe = 1'b0;
                    end else begin
                        next_r.scl_oe = 1'b1;
                        next_r.ph = 1'b0;
                        next_r.byte_n = r.byte_n + 2'h1;
                        if (!rx_byte && sda) begin
                            next_r.nack = 1'b1;
                            next_r.st = rsp_pkg::RSP_M_STOP;
                        end else if (rx_byte || (r.byte_n == 2'h2 && !r.rd)) begin
                            next_r.st = rsp_pkg::RSP_M_STOP;
                        end else if (r.byte_n == 2'h1 && r.rd) begin
                            next_r.st = rsp_pkg::RSP_M_RSTART;
                        end else begin
                            next_r.st = rsp_pkg::RSP_M_BIT;
                            next_r.bit_n = 3'h7;
                            next_r.sh = (r.byte_n == 2'h0) ? {2'h0, reg_i} : wdata_i;
                        end
                    end
                end
                rsp_pkg::RSP_M_RSTART: begin
                    if (r.scl_oe) begin
                        next_r.sda_oe = 1'b0;
                        next_r.scl_oe = 1'b0;
                    end else begin
                        next_r.sda_oe = 1'b1;
                        next_r.st = rsp_pkg::RSP_M_START;
                    end
                end
                rsp_pkg::RSP_M_STOP: begin
                    if (!r.ph) begin
                        next_r.sda_oe = 1'b1;
                        next_r.ph = 1'b1;
                    end else if (r.scl_oe) begin
                        next_r.scl_oe = 1'b0;
                    end else begin
                        next_r.sda_oe = 1'b0;
                        next_r.ph = 1'b0;
                        next_r.st = rsp_pkg::RSP_M_DONE;
                    end
                end
                rsp_pkg::RSP_M_DONE: begin
                    next_r.done = 1'b1;
                    next_r.st = rsp_pkg::RSP_M_IDLE;
                end
                default: next_r.st = rsp_pkg::RSP_M_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            r <= '{sda_sy: 2'h3, st: rsp_pkg::RSP_M_IDLE, div: 16'h0000, ph: 1'b0, bit_n: 3'h7,
                   byte_n: 2'h0, sh: 8'h00, scl_oe: 1'b0, sda_oe: 1'b0, rd: 1'b0, done: 1'b0,
                   nack: 1'b0, rdata: 8'h00};
        end else begin
            r <= next_r;
        end
    end

    assign bus.scl_m_oe = r.scl_oe;
    assign bus.sda_m_oe = r.sda_oe;
    assign busy_o = (r.st != rsp_pkg::RSP_M_IDLE);
    assign done_o = r.done;
    assign nack_o = r.nack;
    assign rdata_o = r.rdata;
endmodule
`default_nettype wire

// ### verif/rsp_checker.sv
// Wire-level checker for the regulator serial port bus.
// Assumes the testbench hands it the bus interface signals and the slave clock.
`default_nettype none
`include "rsp_cfg.svh"
module rsp_checker (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic scl_m_oe,
    input wire logic sda_m_oe,
    input wire logic sda_s_oe,
    input wire logic scl,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    // ---------------------------------------------------------------
    // Bus decoder
    // ---------------------------------------------------------------
    // Own decode of the wire, independent of the slave's synchronisers
    logic scl_q, sda_q, rw, addr_ok, cmd_ok;
    logic [3:0] bitn;
    logic [1:0] byten;
    logic [7:0] sh, byte_q;
    logic start_c, stop_c, rise_c, hi2, tx;
    assign start_c = scl && scl_q && sda_q && !sda;
    assign stop_c = scl && scl_q && !sda_q && sda;
    assign rise_c = scl && !scl_q;
    // Any cycle of a high phase after the first, so bit counters have settled
    assign hi2 = scl && scl_q;
    assign tx = rw && byten == 2'h1;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            bitn <= 4'h0;
            byten <= 2'h0;
            rw <= 1'b0;
            addr_ok <= 1'b0;
            cmd_ok <= 1'b0;
            sh <= 8'h00;
            byte_q <= 8'h00;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            if (start_c || stop_c) begin
                bitn <= 4'h0;
                byten <= 2'h0;
                rw <= 1'b0;
                addr_ok <= 1'b0;
            end else if (rise_c) begin
                bitn <= (bitn == 4'h9) ? 4'h1 : bitn + 4'h1;
                sh <= {sh[6:0], sda};
                if (bitn == 4'h7) byte_q <= {sh[6:0], sda};
                if (bitn == 4'h7 && byten == 2'h0) rw <= sda;
                if (bitn == 4'h9 && byten != 2'h3) byten <= byten + 2'h1;
                if (bitn == 4'h9 && byten == 2'h0) addr_ok <= byte_q[7:1] == `RSP_SLAVE_ADDR;
                if (bitn == 4'h9 && byten == 2'h1) cmd_ok <= byte_q[5:0] <= `RSP_REG_LAST;
            end
        end
    end

    // ---------------------------------------------------------------
    // Properties
    // ---------------------------------------------------------------
    // Bench master holds the clock low for two half periods at most
    localparam int SCL_LOW_MAX = 40;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    a_no_clock_stretch: assert property ($fell(scl) |-> ##[1:SCL_LOW_MAX] scl)
        else $error("clock held low too long");
    a_sda_change_low: assert property ($changed(sda_s_oe) |-> !scl)
        else $error("slave moved data while clock high");
    a_ack_setup_time: assert property ($rose(sda_s_oe) |-> !scl [*2])
        else $error("slave drive too close to clock rise");
    a_addr_ack_match: assert property (
        hi2 && bitn == 4'h9 && byten == 2'h0 |-> sda_s_oe == (byte_q[7:1] == `RSP_SLAVE_ADDR))
        else $error("address acknowledge wrong");
    a_cmd_ack_range: assert property (
        hi2 && bitn == 4'h9 && byten == 2'h1 && !rw && addr_ok |-> sda_s_oe == (byte_q[5:0] <= `RSP_REG_LAST))
        else $error("command acknowledge wrong");
    a_data_ack_write: assert property (
        hi2 && bitn == 4'h9 && byten == 2'h2 && !rw && addr_ok && cmd_ok |-> sda_s_oe)
        else $error("write data not acknowledged");
    a_wrong_addr_quiet: assert property (hi2 && byten != 2'h0 && !addr_ok |-> !sda_s_oe)
        else $error("slave active after foreign address");
    a_rx_bits_free: assert property (hi2 && bitn inside {[4'h1:4'h8]} && !tx |-> !sda_s_oe)
        else $error("slave drove data while receiving");
    a_tx_nack_release: assert property (hi2 && bitn == 4'h9 && tx |-> !sda_s_oe && !sda_m_oe)
        else $error("read byte end not released");
    a_stop_release: assert property (stop_c |=> !sda_s_oe [*4])
        else $error("slave drove data after stop");

    c_repeated_start: cover property (start_c && byten != 2'h0);
    c_write_data_ack: cover property (hi2 && bitn == 4'h9 && byten == 2'h2 && sda_s_oe);
    c_read_byte_end: cover property (hi2 && bitn == 4'h9 && tx);
    c_cmd_refused: cover property (hi2 && bitn == 4'h9 && byten == 2'h1 && addr_ok && !sda_s_oe);
endmodule
`default_nettype wire

// ### verif/testbench.sv
// Testbench: master end and slave end facing each other over one bus.
// Assumes src/ files compiled first; slave register file modelled here.
`default_nettype none
`include "rsp_cfg.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    // Short bit time keeps the run small; slave needs four cycles a phase
    localparam int HALF = 8;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic req_i = 1'b0;
    logic rd_i = 1'b0;
    logic [6:0] dev_i = 7'h00;
    logic [5:0] reg_i = 6'h00;
    logic [7:0] wdata_i = 8'h00;
    logic m_busy, m_done, m_nack, wr_en, s_busy;
    logic [7:0] rdata, wr_data, rd_data;
    logic [5:0] wr_addr, rd_addr;
    logic [7:0] regs [0:63] = '{default: 8'h00};
    logic [7:0] pat [0:3] = '{8'ha5, 8'h81, 8'hff, 8'h3c};
    int num_errors = 0;
    int comparisons = 0;
    int writes = 0;

    initial begin
        forever #25 clk_i = ~clk_i;
    end

    rsp_bus_if rsp_bus_if_i ();
    rsp_slave rsp_slave_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .bus(rsp_bus_if_i.device),
        .wr_en_o(wr_en), .wr_addr_o(wr_addr), .wr_data_o(wr_data), .rd_addr_o(rd_addr),
        .rd_data_i(rd_data), .busy_o(s_busy));
    rsp_master #(.HALF(HALF)) rsp_master_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .bus(rsp_bus_if_i.master), .req_i(req_i), .rd_i(rd_i), .dev_i(dev_i), .reg_i(reg_i),
        .wdata_i(wdata_i), .busy_o(m_busy), .done_o(m_done), .nack_o(m_nack), .rdata_o(rdata));
    rsp_checker rsp_checker_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .scl_m_oe(rsp_bus_if_i.scl_m_oe),
        .sda_m_oe(rsp_bus_if_i.sda_m_oe), .sda_s_oe(rsp_bus_if_i.sda_s_oe), .scl(rsp_bus_if_i.scl),
        .sda(rsp_bus_if_i.sda));

    // ---------------------------------------------------------------
    // Register file on the slave's user side
    // ---------------------------------------------------------------
    assign rd_data = regs[rd_addr];
    always @(posedge clk_i) begin
        if (wr_en === 1'b1) begin
            regs[wr_addr] <= wr_data;
            writes++;
        end
    end

    // ---------------------------------------------------------------
    // Tasks
    // ---------------------------------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // One whole transaction; request held until the done pulse
    task automatic xfer(input logic rd, input logic [6:0] dev, input logic [5:0] rg,
                        input logic [7:0] wd, input logic exp_nack, input logic [7:0] exp_rd);
        int n;
        int w0;
        logic seen;
        n = 0;
        w0 = writes;
        seen = 1'b0;
        @(negedge clk_i);
        req_i = 1'b1;
        rd_i = rd;
        dev_i = dev;
        reg_i = rg;
        wdata_i = wd;
        while (m_done !== 1'b1 && n < 20000) begin
            @(negedge clk_i);
            seen |= (s_busy === 1'b1);
            n++;
        end
        check({7'h00, n < 20000}, 8'h01);
        check({7'h00, m_nack}, {7'h00, exp_nack});
        if (rd && !exp_nack) check(rdata, exp_rd);
        req_i = 1'b0;
        repeat (6) @(negedge clk_i);
        check({7'h00, dev == `RSP_SLAVE_ADDR && !seen}, 8'h00);
        check({7'h00, s_busy}, 8'h00);
        check({7'h00, m_busy}, 8'h00);
        check(8'(writes - w0), {7'h00, !rd && !exp_nack});
    endtask

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        repeat (4) @(negedge clk_i);
        sys_rst_i = 1'b0;
        for (int i = 0; i < 4; i++) xfer(1'b0, `RSP_SLAVE_ADDR, 6'(i), pat[i], 1'b0, 8'h00);
        xfer(1'b0, `RSP_SLAVE_ADDR, 6'h04, 8'h77, 1'b1, 8'h00);
        xfer(1'b0, `RSP_SLAVE_ADDR, 6'h3f, 8'h77, 1'b1, 8'h00);
        xfer(1'b0, 7'h5a, 6'h00, 8'h77, 1'b1, 8'h00);
        xfer(1'b0, 7'h1b, 6'h01, 8'h77, 1'b1, 8'h00);
        for (int i = 0; i < 4; i++) xfer(1'b1, `RSP_SLAVE_ADDR, 6'(i), 8'h00, 1'b0, pat[i]);
        xfer(1'b1, `RSP_SLAVE_ADDR, 6'h04, 8'h00, 1'b1, 8'h00);
        xfer(1'b1, 7'h5a, 6'h02, 8'h00, 1'b1, 8'h00);
        check(regs[4], 8'h00);
        end_sim();
    end

    // Whole run is 14 transfers of under 1000 cycles each
    initial begin
        #4000000;
        num_errors++;
        end_sim();
    end
endmodule
`default_nettype wire
